//--- logic/rafc_cfg.svh
// Register map, field positions, reset values and timing counts of the regeneration avoidance block.
`ifndef RAFC_CFG_SVH
`define RAFC_CFG_SVH

`define RAFC_ADDR_MODE 12'h000
`define RAFC_ADDR_LEVEL 12'h004
`define RAFC_ADDR_LIMIT 12'h008
`define RAFC_ADDR_VGAIN 12'h00C
`define RAFC_ADDR_FGAIN 12'h010
`define RAFC_ADDR_FMAX 12'h014
`define RAFC_ADDR_GROUP 12'h018
`define RAFC_ADDR_ITEM 12'h01C
`define RAFC_ADDR_TIMER 12'h020
`define RAFC_ADDR_STATE 12'h024
`define RAFC_ADDR_EVT 12'h028
`define RAFC_ADDR_EVT_CLR 12'h02C
`define RAFC_ADDR_EVT_EN 12'h030
`define RAFC_ADDR_FREQ 12'h034

`define RAFC_MODE_OFF 2'h0
`define RAFC_MODE_ALWAYS 2'h1
`define RAFC_MODE_CONST 2'h2

`define RAFC_LEVEL_MIN 10'h12C
`define RAFC_LEVEL_MAX 10'h320
`define RAFC_LEVEL_RST_200 10'h190
`define RAFC_LEVEL_RST_400 10'h30C

`define RAFC_LIMIT_MAX 16'h03E8
`define RAFC_LIMIT_OFF 16'h270F
`define RAFC_LIMIT_RST 16'h0258

`define RAFC_GAIN_MAX 8'hC8
`define RAFC_GAIN_RST 8'h64
`define RAFC_FMAX_RST 16'h1770

`define RAFC_ITEM_CUR_BIT 0
`define RAFC_ITEM_OV_BIT 1
`define RAFC_ITEM_RST 2'h3
`define RAFC_TIMER_RST 8'h00

`define RAFC_EVT_START_BIT 0
`define RAFC_EVT_END_BIT 1
`define RAFC_EVT_HOLD_BIT 2
`define RAFC_EVT_OL_BIT 3
`define RAFC_EVT_REJ_BIT 4

`define RAFC_DECAY_STEP 16'h000A

`define RAFC_CLK_NS 100
`define RAFC_UPDATE_NS 1000
`define RAFC_UPDATE_CYCLES ((`RAFC_UPDATE_NS + `RAFC_CLK_NS - 1) / `RAFC_CLK_NS)
`define RAFC_TIMER_TICK_NS 100000000
`define RAFC_TIMER_TICK_CYCLES (`RAFC_TIMER_TICK_NS / `RAFC_CLK_NS)

`endif

//--- logic/rafc_pkg.sv
// Types shared by the regeneration avoidance block.
package rafc_pkg;

	typedef enum logic [1:0] {
		RAMP_STOP,
		RAMP_ACCEL,
		RAMP_CONST,
		RAMP_DECEL
	} rafc_ramp_t;

	typedef enum logic [1:0] {
		AVOID_IDLE,
		AVOID_ACTIVE,
		AVOID_HOLD
	} rafc_state_t;

endpackage

//--- logic/rafc_stall_timer.sv
// Qualifying delay for the overload stall output signal.
module rafc_stall_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic cond,
	input wire logic [7:0] delay,
	output logic sig_out
);

	logic [7:0] cnt_q;

	// A zero delay passes the condition straight through with one flop of latency.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 8'h00;
		end else if (!cond) begin
			cnt_q <= 8'h00;
		end else if (tick && cnt_q < delay) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sig_out <= 1'b0;
		end else begin
			sig_out <= cond && (cnt_q >= delay);
		end
	end

endmodule

//--- logic/rafc_top.sv
// Regeneration avoidance frequency compensation with its APB register file.
//
// Functional notes
// - mode 0 off, 1 always, 2 constant speed
// - bus voltage at or above level raises frequency
// - level 300 to 800 V, class default
// - compensation limit 0 to 10 Hz, default 6
// - limit value 9999 removes the limit
// - accel or constant: base plus limit ceiling
// - decel overshoot holds limit until half limit
// - raised frequency clamped to maximum frequency
// - voltage gain 0 to 200 percent, default 100
// - frequency gain 0 to 200 percent scales correction
// - avoidance activity also activates stall prevention
// - avoidance counts as overvoltage stall for signal
// - settings writable only when group select zero
//
// Our own choices: the register offsets and register access over APB.
`include "rafc_cfg.svh"

module rafc_top #(
	parameter logic CLASS_400V = 1'b0,
	parameter int TIMER_TICK_CYCLES = `RAFC_TIMER_TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] ramp_freq,
	input wire rafc_pkg::rafc_ramp_t ramp_phase,
	input wire logic [9:0] bus_voltage,
	input wire logic current_stall,
	output logic [15:0] freq_cmd,
	output logic regen_avoid_active,
	output logic stall_prevention_active,
	output logic overload_stall_signal,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic [15:0] rafc_scale(input logic [15:0] x, input logic [7:0] pct);
		logic [23:0] prod;
		prod = {8'h00, x} * {16'h0000, pct};
		return 16'(prod / 24'h000064);
	endfunction

	function automatic logic [16:0] rafc_min(input logic [16:0] a, input logic [16:0] b);
		return (a < b) ? a : b;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register bus.

	logic [1:0] mode_q;
	logic [9:0] level_q;
	logic [15:0] limit_q;
	logic [7:0] vgain_q;
	logic [7:0] fgain_q;
	logic [15:0] fmax_q;
	logic [7:0] group_q;
	logic [1:0] item_q;
	logic [7:0] timer_q;
	logic [4:0] evt_q;
	logic [4:0] evt_en_q;
	logic [4:0] evt_set;
	logic [31:0] rdata_d;
	logic addr_ok;
	logic wr_acc;
	logic rd_setup;
	logic wr_setting;
	logic wr_bad;
	logic [15:0] wlo;
	rafc_pkg::rafc_state_t state_q;

	assign wr_acc = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign wlo = pwdata[15:0];
	assign pready = 1'b1;

	always_comb begin
		addr_ok = 1'b1;
		rdata_d = 32'h00000000;
		unique case (paddr)
			`RAFC_ADDR_MODE: rdata_d = {30'h00000000, mode_q};
			`RAFC_ADDR_LEVEL: rdata_d = {22'h000000, level_q};
			`RAFC_ADDR_LIMIT: rdata_d = {16'h0000, limit_q};
			`RAFC_ADDR_VGAIN: rdata_d = {24'h000000, vgain_q};
			`RAFC_ADDR_FGAIN: rdata_d = {24'h000000, fgain_q};
			`RAFC_ADDR_FMAX: rdata_d = {16'h0000, fmax_q};
			`RAFC_ADDR_GROUP: rdata_d = {24'h000000, group_q};
			`RAFC_ADDR_ITEM: rdata_d = {30'h00000000, item_q};
			`RAFC_ADDR_TIMER: rdata_d = {24'h000000, timer_q};
			`RAFC_ADDR_STATE: rdata_d = {28'h0000000, overload_stall_signal,
				stall_prevention_active, state_q == rafc_pkg::AVOID_HOLD, regen_avoid_active};
			`RAFC_ADDR_EVT: rdata_d = {27'h0000000, evt_q};
			`RAFC_ADDR_EVT_CLR: rdata_d = 32'h00000000;
			`RAFC_ADDR_EVT_EN: rdata_d = {27'h0000000, evt_en_q};
			`RAFC_ADDR_FREQ: rdata_d = {16'h0000, freq_cmd};
			default: addr_ok = 1'b0;
		endcase
	end

	// A setting write is refused while the group select is non-zero or the value is out of range.
	always_comb begin
		wr_setting = 1'b0;
		wr_bad = 1'b0;
		unique case (paddr)
			`RAFC_ADDR_MODE: begin
				wr_setting = 1'b1;
				wr_bad = wlo > 16'(`RAFC_MODE_CONST);
			end
			`RAFC_ADDR_LEVEL: begin
				wr_setting = 1'b1;
				wr_bad = wlo < 16'(`RAFC_LEVEL_MIN) || wlo > 16'(`RAFC_LEVEL_MAX);
			end
			`RAFC_ADDR_LIMIT: begin
				wr_setting = 1'b1;
				wr_bad = wlo > `RAFC_LIMIT_MAX && wlo != `RAFC_LIMIT_OFF;
			end
			`RAFC_ADDR_VGAIN, `RAFC_ADDR_FGAIN: begin
				wr_setting = 1'b1;
				wr_bad = wlo > 16'(`RAFC_GAIN_MAX);
			end
			`RAFC_ADDR_FMAX, `RAFC_ADDR_ITEM, `RAFC_ADDR_TIMER: begin
				wr_setting = 1'b1;
			end
			default: begin
				wr_setting = 1'b0;
			end
		endcase
	end

	logic wr_ok;
	logic wr_reject;
	assign wr_reject = wr_acc && wr_setting && (group_q != 8'h00 || wr_bad);
	assign wr_ok = wr_acc && wr_setting && !wr_reject;
	assign pslverr = psel && penable && (!addr_ok || wr_reject);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= rdata_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= `RAFC_MODE_OFF;
			level_q <= CLASS_400V ? `RAFC_LEVEL_RST_400 : `RAFC_LEVEL_RST_200;
			limit_q <= `RAFC_LIMIT_RST;
			vgain_q <= `RAFC_GAIN_RST;
			fgain_q <= `RAFC_GAIN_RST;
			fmax_q <= `RAFC_FMAX_RST;
			item_q <= `RAFC_ITEM_RST;
			timer_q <= `RAFC_TIMER_RST;
		end else if (wr_ok) begin
			unique case (paddr)
				`RAFC_ADDR_MODE: mode_q <= pwdata[1:0];
				`RAFC_ADDR_LEVEL: level_q <= pwdata[9:0];
				`RAFC_ADDR_LIMIT: limit_q <= wlo;
				`RAFC_ADDR_VGAIN: vgain_q <= pwdata[7:0];
				`RAFC_ADDR_FGAIN: fgain_q <= pwdata[7:0];
				`RAFC_ADDR_FMAX: fmax_q <= wlo;
				`RAFC_ADDR_ITEM: item_q <= pwdata[1:0];
				`RAFC_ADDR_TIMER: timer_q <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// The group select itself stays writable, otherwise a locked device could never be unlocked.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_q <= 8'h00;
		end else if (wr_acc && paddr == `RAFC_ADDR_GROUP) begin
			group_q <= pwdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control update rate and timer tick.

	logic [3:0] upd_cnt_q;
	logic upd_tick;
	logic [31:0] tmr_cnt_q;
	logic tmr_tick;

	assign upd_tick = upd_cnt_q == 4'(`RAFC_UPDATE_CYCLES - 1);
	assign tmr_tick = tmr_cnt_q == 32'(TIMER_TICK_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upd_cnt_q <= 4'h0;
		end else begin
			upd_cnt_q <= upd_tick ? 4'h0 : upd_cnt_q + 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_cnt_q <= 32'h00000000;
		end else begin
			tmr_cnt_q <= tmr_tick ? 32'h00000000 : tmr_cnt_q + 32'h00000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avoidance control.

	logic [15:0] base_q;
	logic [15:0] comp_q;
	logic enabled;
	logic trigger;
	logic [15:0] incr;
	logic [16:0] raw;
	logic [16:0] ceil;
	logic [16:0] lim_freq;
	logic over_ceil;
	logic no_limit;

	assign no_limit = limit_q == `RAFC_LIMIT_OFF;
	assign enabled = mode_q == `RAFC_MODE_ALWAYS ||
		(mode_q == `RAFC_MODE_CONST && ramp_phase == rafc_pkg::RAMP_CONST);
	assign trigger = enabled && bus_voltage >= level_q;
	// The gains are applied one after the other so that each can be trimmed on its own.
	assign incr = rafc_scale(rafc_scale({6'h00, bus_voltage - level_q}, vgain_q), fgain_q);
	assign raw = {1'b0, ramp_freq} + {1'b0, comp_q};
	assign ceil = {1'b0, base_q} + {1'b0, limit_q};
	assign over_ceil = !no_limit && raw > ceil;

	always_comb begin
		lim_freq = raw;
		if (state_q == rafc_pkg::AVOID_HOLD || (over_ceil && ramp_phase != rafc_pkg::RAMP_DECEL)) begin
			lim_freq = ceil;
		end
		lim_freq = rafc_min(lim_freq, {1'b0, fmax_q});
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= rafc_pkg::AVOID_IDLE;
		end else if (upd_tick) begin
			unique case (state_q)
				rafc_pkg::AVOID_IDLE: begin
					if (trigger) begin
						state_q <= rafc_pkg::AVOID_ACTIVE;
					end
				end
				rafc_pkg::AVOID_ACTIVE: begin
					if (over_ceil && ramp_phase == rafc_pkg::RAMP_DECEL) begin
						state_q <= rafc_pkg::AVOID_HOLD;
					end else if (!trigger && comp_q <= `RAFC_DECAY_STEP) begin
						state_q <= rafc_pkg::AVOID_IDLE;
					end
				end
				rafc_pkg::AVOID_HOLD: begin
					if ({ramp_freq, 1'b0} <= {1'b0, limit_q}) begin
						state_q <= rafc_pkg::AVOID_IDLE;
					end
				end
			endcase
		end
	end

	// The base frequency is frozen at entry so the ceiling does not creep up with the compensation.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_q <= 16'h0000;
		end else if (upd_tick && state_q == rafc_pkg::AVOID_IDLE && trigger) begin
			base_q <= ramp_freq;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comp_q <= 16'h0000;
		end else if (upd_tick) begin
			if (state_q == rafc_pkg::AVOID_HOLD || (state_q == rafc_pkg::AVOID_IDLE && !trigger)) begin
				comp_q <= 16'h0000;
			end else if (trigger) begin
				comp_q <= 16'(rafc_min({1'b0, comp_q} + {1'b0, incr}, {1'b0, fmax_q}));
			end else if (comp_q > `RAFC_DECAY_STEP) begin
				comp_q <= comp_q - `RAFC_DECAY_STEP;
			end else begin
				comp_q <= 16'h0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			freq_cmd <= 16'h0000;
		end else if (state_q == rafc_pkg::AVOID_IDLE) begin
			freq_cmd <= ramp_freq;
		end else begin
			freq_cmd <= lim_freq[15:0];
		end
	end

	assign regen_avoid_active = state_q != rafc_pkg::AVOID_IDLE;
	assign stall_prevention_active = regen_avoid_active;

	////////////////////////////////////////////////////////////////////////////////
	// Overload stall signal.

	logic ol_cond;
	assign ol_cond = (item_q[`RAFC_ITEM_CUR_BIT] && current_stall) ||
		(item_q[`RAFC_ITEM_OV_BIT] && regen_avoid_active);

	rafc_stall_timer u_stall_timer (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tmr_tick),
		.cond(ol_cond),
		.delay(timer_q),
		.sig_out(overload_stall_signal)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Events and interrupt.

	logic active_d1_q;
	logic hold_d1_q;
	logic ol_d1_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_d1_q <= 1'b0;
			hold_d1_q <= 1'b0;
			ol_d1_q <= 1'b0;
		end else begin
			active_d1_q <= regen_avoid_active;
			hold_d1_q <= state_q == rafc_pkg::AVOID_HOLD;
			ol_d1_q <= overload_stall_signal;
		end
	end

	always_comb begin
		evt_set = 5'h00;
		evt_set[`RAFC_EVT_START_BIT] = regen_avoid_active && !active_d1_q;
		evt_set[`RAFC_EVT_END_BIT] = !regen_avoid_active && active_d1_q;
		evt_set[`RAFC_EVT_HOLD_BIT] = state_q == rafc_pkg::AVOID_HOLD && !hold_d1_q;
		evt_set[`RAFC_EVT_OL_BIT] = overload_stall_signal && !ol_d1_q;
		evt_set[`RAFC_EVT_REJ_BIT] = wr_reject;
	end

	// A new event in the clearing cycle survives the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q <= 5'h00;
		end else if (wr_acc && paddr == `RAFC_ADDR_EVT_CLR) begin
			evt_q <= (evt_q & ~pwdata[4:0]) | evt_set;
		end else begin
			evt_q <= evt_q | evt_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_en_q <= 5'h00;
		end else if (wr_acc && paddr == `RAFC_ADDR_EVT_EN) begin
			evt_en_q <= pwdata[4:0];
		end
	end

	assign irq = |(evt_q & evt_en_q);

endmodule

//--- testbench/rafc_monitor.sv
// Port checker of the regeneration avoidance block.
`include "rafc_cfg.svh"
module rafc_monitor #(
	parameter logic CLASS_400V = 1'b0,
	parameter int TIMER_TICK_CYCLES = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] ramp_freq,
	input wire rafc_pkg::rafc_ramp_t ramp_phase,
	input wire logic [9:0] bus_voltage,
	input wire logic current_stall,
	input wire logic [15:0] freq_cmd,
	input wire logic regen_avoid_active,
	input wire logic stall_prevention_active,
	input wire logic overload_stall_signal,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] mode_s;
	logic [9:0] lvl_s;
	logic [15:0] fmax_s;
	logic grp_nz;
	logic itm_ov;
	logic tmr_z;
	logic [3:0] trig_cnt;
	logic wr;
	assign wr = psel && penable && pwrite;
	////////////////////////////////////////
	// Shadow copies of accepted writes, since the checker cannot see the registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_s <= `RAFC_MODE_OFF;
			lvl_s <= CLASS_400V ? `RAFC_LEVEL_RST_400 : `RAFC_LEVEL_RST_200;
			fmax_s <= `RAFC_FMAX_RST;
			grp_nz <= 1'b0;
			itm_ov <= 1'b1;
			tmr_z <= 1'b1;
		end else if (wr && !pslverr) begin
			case (paddr)
				`RAFC_ADDR_MODE: mode_s <= pwdata[1:0];
				`RAFC_ADDR_LEVEL: lvl_s <= pwdata[9:0];
				`RAFC_ADDR_FMAX: fmax_s <= pwdata[15:0];
				`RAFC_ADDR_GROUP: grp_nz <= pwdata[7:0] != 8'h00;
				`RAFC_ADDR_ITEM: itm_ov <= pwdata[`RAFC_ITEM_OV_BIT];
				`RAFC_ADDR_TIMER: tmr_z <= pwdata[7:0] == 8'h00;
				default: ;
			endcase
		end
	end
	// Cycles of an uninterrupted trigger; decel is left out because a hold exit may re-arm.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) trig_cnt <= 4'h0;
		else if (mode_s != `RAFC_MODE_ALWAYS || bus_voltage < lvl_s) trig_cnt <= 4'h0;
		else if (ramp_phase == rafc_pkg::RAMP_DECEL) trig_cnt <= 4'h0;
		else if (trig_cnt != 4'hF) trig_cnt <= trig_cnt + 4'h1;
	end
	////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_mode;
		$rose(regen_avoid_active) |-> $past(mode_s) != `RAFC_MODE_OFF &&
			($past(mode_s) != `RAFC_MODE_CONST || $past(ramp_phase) == rafc_pkg::RAMP_CONST);
	endproperty
	property p_level;
		$rose(regen_avoid_active) |-> $past(bus_voltage) >= $past(lvl_s);
	endproperty
	property p_react;
		trig_cnt == 4'hF |-> regen_avoid_active;
	endproperty
	property p_fmax;
		freq_cmd <= $past(fmax_s);
	endproperty
	property p_stall;
		stall_prevention_active == regen_avoid_active;
	endproperty
	property p_ol;
		regen_avoid_active && tmr_z && itm_ov ##1 regen_avoid_active |-> ##[0:2] overload_stall_signal;
	endproperty
	property p_group;
		wr && grp_nz && paddr <= `RAFC_ADDR_FMAX |-> pslverr;
	endproperty
	property p_lvl_rng;
		wr && paddr == `RAFC_ADDR_LEVEL && (pwdata < 32'h12C || pwdata > 32'h320) |-> pslverr;
	endproperty
	property p_lim_rng;
		wr && paddr == `RAFC_ADDR_LIMIT && pwdata > 32'h3E8 && pwdata != 32'h270F |-> pslverr;
	endproperty
	a_mode: assert property (p_mode) else $error("activation outside enabled mode");
	a_level: assert property (p_level) else $error("activation below level");
	a_react: assert property (p_react) else $error("no activation on trigger");
	a_fmax: assert property (p_fmax) else $error("command above maximum");
	a_stall: assert property (p_stall) else $error("stall prevention differs");
	a_ol: assert property (p_ol) else $error("overload signal missing");
	a_group: assert property (p_group) else $error("write accepted in group");
	a_lvl_rng: assert property (p_lvl_rng) else $error("level range accepted");
	a_lim_rng: assert property (p_lim_rng) else $error("limit range accepted");
	c_active: cover property ($rose(regen_avoid_active));
	c_ol: cover property ($rose(overload_stall_signal));
	c_refuse: cover property (wr && pslverr);
endmodule
bind rafc_top rafc_monitor #(.CLASS_400V(CLASS_400V), .TIMER_TICK_CYCLES(TIMER_TICK_CYCLES)) u_mon (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ramp_freq(ramp_freq), .ramp_phase(ramp_phase), .bus_voltage(bus_voltage),
	.current_stall(current_stall), .freq_cmd(freq_cmd), .regen_avoid_active(regen_avoid_active),
	.stall_prevention_active(stall_prevention_active),
	.overload_stall_signal(overload_stall_signal), .irq(irq));

//--- testbench/rafc_plant.sv
// Model of the bus voltage sensing and ramp generator beside the block.
module rafc_plant (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [9:0] v_set,
	input wire logic [15:0] f_set,
	input wire rafc_pkg::rafc_ramp_t ph_set,
	input wire logic cs_set,
	output logic [9:0] bus_voltage,
	output logic [15:0] ramp_freq,
	output rafc_pkg::rafc_ramp_t ramp_phase,
	output logic current_stall
);
	timeunit 1ns;
	timeprecision 1ns;
	// Values arrive one sample late, as from a real converter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_voltage <= 10'h000;
			ramp_freq <= 16'h0000;
			ramp_phase <= rafc_pkg::RAMP_STOP;
			current_stall <= 1'b0;
		end else begin
			bus_voltage <= v_set;
			ramp_freq <= f_set;
			ramp_phase <= ph_set;
			current_stall <= cs_set;
		end
	end
endmodule

//--- testbench/tb_rafc_top.sv
// Self-checking bench of the regeneration avoidance block.
`include "rafc_cfg.svh"
module tb_rafc_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [9:0] v_set = 10'h15E;
	logic [15:0] f_set = 16'h03E8;
	rafc_pkg::rafc_ramp_t ph_set = rafc_pkg::RAMP_CONST;
	logic cs_set = 1'b0;
	logic [9:0] bus_voltage;
	logic [15:0] ramp_freq;
	rafc_pkg::rafc_ramp_t ramp_phase;
	logic current_stall;
	logic [15:0] freq_cmd;
	logic act;
	logic spa;
	logic ol;
	logic irq;
	int error_cnt = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic [15:0] f0;
	logic [11:0] ra [11] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
		12'h018, 12'h01C, 12'h020, 12'h028, 12'h030};
	logic [31:0] rv [11] = '{32'h0, 32'h190, 32'h258, 32'h64, 32'h64, 32'h1770,
		32'h0, 32'h3, 32'h0, 32'h0, 32'h0};
	logic [11:0] wa [9] = '{12'h004, 12'h004, 12'h004, 12'h004, 12'h008, 12'h008,
		12'h000, 12'h00C, 12'h010};
	logic [31:0] wd [9] = '{32'h12B, 32'h321, 32'h12C, 32'h320, 32'h3E9, 32'h270F,
		32'h3, 32'hC9, 32'hC9};
	logic we [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	logic [31:0] gv [4] = '{32'h64, 32'hC8, 32'h64, 32'hC8};
	logic [31:0] gf [4] = '{32'h64, 32'h64, 32'h32, 32'h32};
	always #50 pclk = ~pclk;
	rafc_plant plant (.pclk(pclk), .presetn(presetn), .v_set(v_set), .f_set(f_set),
		.ph_set(ph_set), .cs_set(cs_set), .bus_voltage(bus_voltage), .ramp_freq(ramp_freq),
		.ramp_phase(ramp_phase), .current_stall(current_stall));
	rafc_top #(.CLASS_400V(1'b0), .TIMER_TICK_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ramp_freq(ramp_freq),
		.ramp_phase(ramp_phase), .bus_voltage(bus_voltage), .current_stall(current_stall),
		.freq_cmd(freq_cmd), .regen_avoid_active(act), .stall_prevention_active(spa),
		.overload_stall_signal(ol), .irq(irq));
	////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Response and read data are taken at the rising edge that completes the access phase.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		check("pslverr", {31'h0, pslverr}, {31'h0, e});
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge pclk);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge pclk);
	endtask
	task automatic wait_act(input logic want);
		int n;
		n = 0;
		while (act !== want && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		check("active", {31'h0, act}, {31'h0, want});
	endtask
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#3000000;
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			apb(1'b0, ra[i], 32'h0, 1'b0);
			check("reset value", rd, rv[i]);
		end
		apb(1'b0, 12'h038, 32'h0, 1'b1);
		check("unmapped", rd, 32'h0);
		for (int i = 0; i < 9; i++) apb(1'b1, wa[i], wd[i], we[i]);
		apb(1'b0, 12'h004, 32'h0, 1'b0);
		check("level", rd, 32'h320);
		apb(1'b1, 12'h004, 32'h190, 1'b0);
		apb(1'b1, 12'h008, 32'h258, 1'b0);
		apb(1'b1, 12'h018, 32'h1, 1'b0);
		apb(1'b1, 12'h000, 32'h1, 1'b1);
		apb(1'b0, 12'h000, 32'h0, 1'b0);
		check("mode", rd, 32'h0);
		apb(1'b1, 12'h018, 32'h0, 1'b0);
		@(posedge pclk) v_set <= 10'h1C2;
		cyc(40);
		check("active", {31'h0, act}, 32'h0);
		check("freq", {16'h0, freq_cmd}, 32'h3E8);
		apb(1'b1, 12'h02C, 32'h1F, 1'b0);
		apb(1'b1, 12'h030, 32'h1, 1'b0);
		apb(1'b1, 12'h000, 32'h1, 1'b0);
		wait_act(1'b1);
		cyc(3);
		check("irq", {31'h0, irq}, 32'h1);
		check("stall prevention", {31'h0, spa}, 32'h1);
		check("overload", {31'h0, ol}, 32'h1);
		apb(1'b0, 12'h028, 32'h0, 1'b0);
		check("event start", rd & 32'h1, 32'h1);
		apb(1'b1, 12'h030, 32'h0, 1'b0);
		check("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, 12'h030, 32'h1, 1'b0);
		apb(1'b1, 12'h02C, 32'h1, 1'b0);
		check("irq cleared", {31'h0, irq}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk) v_set <= 10'h15E;
			wait_act(1'b0);
			apb(1'b1, 12'h00C, gv[i], 1'b0);
			apb(1'b1, 12'h010, gf[i], 1'b0);
			@(posedge pclk) v_set <= 10'h1C2;
			wait_act(1'b1);
			cyc(3);
			f0 = freq_cmd;
			cyc(10);
			check("step", {16'h0, freq_cmd - f0}, 32'd50 * gv[i] / 100 * gf[i] / 100);
		end
		cyc(400);
		check("ceiling", {16'h0, freq_cmd}, 32'h640);
		apb(1'b0, 12'h034, 32'h0, 1'b0);
		check("freq reg", rd, 32'h640);
		apb(1'b1, 12'h008, 32'h270F, 1'b0);
		apb(1'b1, 12'h014, 32'h708, 1'b0);
		cyc(100);
		check("fmax", {16'h0, freq_cmd}, 32'h708);
		apb(1'b1, 12'h014, 32'h1770, 1'b0);
		apb(1'b1, 12'h000, 32'h2, 1'b0);
		cyc(100);
		apb(1'b1, 12'h008, 32'h258, 1'b0);
		@(posedge pclk) ph_set <= rafc_pkg::RAMP_DECEL;
		cyc(30);
		check("hold", {16'h0, freq_cmd}, 32'h640);
		apb(1'b0, 12'h024, 32'h0, 1'b0);
		check("state", rd, 32'hF);
		@(posedge pclk) f_set <= 16'h01F4;
		cyc(30);
		check("hold low", {16'h0, freq_cmd}, 32'h640);
		@(posedge pclk) f_set <= 16'h012C;
		cyc(30);
		check("released", {16'h0, freq_cmd}, 32'h12C);
		check("mode const", {31'h0, act}, 32'h0);
		check("overload off", {31'h0, ol}, 32'h0);
		apb(1'b1, 12'h020, 32'h2, 1'b0);
		@(posedge pclk) ph_set <= rafc_pkg::RAMP_CONST;
		apb(1'b1, 12'h000, 32'h1, 1'b0);
		wait_act(1'b1);
		cyc(5);
		check("overload wait", {31'h0, ol}, 32'h0);
		cyc(60);
		check("overload timed", {31'h0, ol}, 32'h1);
		apb(1'b1, 12'h020, 32'h0, 1'b0);
		apb(1'b1, 12'h01C, 32'h1, 1'b0);
		cyc(2);
		check("overload item", {31'h0, ol}, 32'h0);
		@(posedge pclk) cs_set <= 1'b1;
		cyc(3);
		check("overload current", {31'h0, ol}, 32'h1);
		final_report();
	end
endmodule
